//--- hw/clock_divider_output_select.sv
`timescale 1ns/1ps
// How it works
// RQ1 - reference feeds both the output selector and the divider
// RQ2 - divider divides the reference by n, n from 3 to 16383
// RQ3 - pulse_divide_mode output is one 100 ns pulse per n reference cycles
// RQ4 - square path halves the pulse train for 50 percent duty
// RQ5 - selector picks reference, ref/n, ref/2 or square wave
// RQ6 - n is a 14-bit value from switches, on reads 0, off reads 1
// RQ7 - select 00 square, 01 halve, 10 direct, 11 pulse
// RQ8 - first trigger carries the clock when its enable reads 0
// RQ9 - second trigger carries the clock when its enable reads 0
// RQ10 - front panel drives the clock when its enable reads 0
// RQ11 - impedance select 0 low impedance, 1 fifty ohm
// RQ12 - the three output enables act independently
// RQ13 - unused switches must be held off by the configuring party
// RQ14 - for a square wave of total division d, set n to d/2
// RQ15 - no software control, bus only reads back state
// RQ16 - square stage toggles once per pulse, n cycles per phase
// RQ17 - divisors below 3 are unsupported, clamped to 3 here
module clock_divider_output_select
   import clkdiv_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   // reference oscillator, sampled on pclk
   input  wire logic        ref_clk,
   // static switch banks
   input  wire logic [7:0]  divisor_low_switch_bank,
   input  wire logic [7:0]  divisor_high_and_select_bank,
   input  wire logic [3:0]  trigger_enable_bank,
   input  wire logic [3:0]  front_panel_config_bank,
   // outputs
   output logic             trigger_out_first,
   output logic             trigger_out_first_oe_n,
   output logic             trigger_out_second,
   output logic             trigger_out_second_oe_n,
   output logic             front_panel_out,
   output logic             front_panel_oe_n,
   output logic             front_panel_z50,
   // apb slave, read back only
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr
);

   // ===================================================================
   // declarations
   div_if dv ();

   logic        ref_q_reg;
   logic        ref_q2_reg;
   logic        sel_clk_reg;
   logic        sel_clk_next;
   logic        trig_a_reg;
   logic        trig_b_reg;
   logic        fp_reg;
   logic        trig_a_oe_n_reg;
   logic        trig_b_oe_n_reg;
   logic        fp_oe_n_reg;
   logic        fp_z_reg;
   logic [31:0] prdata_reg;
   logic [31:0] rdata_next;
   logic [13:0] raw_divisor;
   logic [1:0]  src_sel;
   logic        trig_a_on;
   logic        trig_b_on;
   logic        fp_on;
   logic        setup_phase;
   logic        access_phase;
   logic        addr_hit;

   // ===================================================================
   // functions

   // below-range divisors run as the minimum divisor
   function automatic logic [13:0] clamp_divisor(input logic [13:0] n);
      clamp_divisor = (n < DIV_MIN) ? DIV_MIN : n;
   endfunction

   // a switch enables its output when it sits on
   function automatic logic switch_on(input logic level);
      switch_on = (level == SW_ON);
   endfunction

   // ===================================================================
   // switch decoding
   // RQ6 - off reads 1
   assign raw_divisor = {divisor_high_and_select_bank[7:DIV_HI_LSB],
                         divisor_low_switch_bank};
   // RQ7 - switch 1 is msb
   assign src_sel     = {divisor_high_and_select_bank[SEL_MSB_POS],
                         divisor_high_and_select_bank[SEL_LSB_POS]};
   // RQ17 - clamp low divisors
   assign dv.divisor  = clamp_divisor(raw_divisor);
   // RQ12 - independent enables
   assign trig_a_on   = switch_on(trigger_enable_bank[TRIG_A_EN_POS]);
   assign trig_b_on   = switch_on(trigger_enable_bank[TRIG_B_EN_POS]);
   assign fp_on       = switch_on(front_panel_config_bank[FP_EN_POS]);

   // ===================================================================
   // reference sampling and tick
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_q_reg  <= 1'b0;
         ref_q2_reg <= 1'b0;
      end else begin
         ref_q_reg  <= ref_clk;
         ref_q2_reg <= ref_q_reg;
      end
   end

   // RQ1 - reference to divider
   assign dv.ref_tick = ref_q_reg & ~ref_q2_reg;

   // ===================================================================
   // divider core
   div_core u_div_core (
      .pclk    (pclk),
      .presetn (presetn),
      .dv      (dv)
   );

   // ===================================================================
   // source multiplexer
   // RQ5 - four way select
   always_comb begin
      unique case (src_sel)
         SEL_SQUARE: sel_clk_next = dv.square;
         SEL_HALVE:  sel_clk_next = dv.half;
         // RQ1 - reference to selector
         SEL_DIRECT: sel_clk_next = ref_q_reg;
         SEL_PULSE:  sel_clk_next = dv.pulse;
      endcase
   end

   // ===================================================================
   // output buffer stage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_clk_reg     <= 1'b0;
         trig_a_reg      <= 1'b0;
         trig_b_reg      <= 1'b0;
         fp_reg          <= 1'b0;
         trig_a_oe_n_reg <= 1'b1;
         trig_b_oe_n_reg <= 1'b1;
         fp_oe_n_reg     <= 1'b1;
         fp_z_reg        <= 1'b1;
      end else begin
         sel_clk_reg     <= sel_clk_next;
         // RQ8 - first trigger gate
         trig_a_reg      <= sel_clk_next & trig_a_on;
         trig_a_oe_n_reg <= ~trig_a_on;
         // RQ9 - second trigger gate
         trig_b_reg      <= sel_clk_next & trig_b_on;
         trig_b_oe_n_reg <= ~trig_b_on;
         // RQ10 - panel gate
         fp_reg          <= sel_clk_next & fp_on;
         fp_oe_n_reg     <= ~fp_on;
         // RQ11 - impedance select
         fp_z_reg        <= front_panel_config_bank[FP_Z_POS];
      end
   end

   assign trigger_out_first       = trig_a_reg;
   assign trigger_out_first_oe_n  = trig_a_oe_n_reg;
   assign trigger_out_second      = trig_b_reg;
   assign trigger_out_second_oe_n = trig_b_oe_n_reg;
   assign front_panel_out         = fp_reg;
   assign front_panel_oe_n        = fp_oe_n_reg;
   assign front_panel_z50         = fp_z_reg;

   // ===================================================================
   // apb read back, writes have no effect
   assign setup_phase  = psel & ~penable;
   assign access_phase = psel & penable;
   assign addr_hit     = (paddr == ADDR_CONFIG) | (paddr == ADDR_STATE)
                       | (paddr == ADDR_BANKS);

   // read data selection
   always_comb begin
      rdata_next = RESET_RDATA;
      unique case (paddr)
         ADDR_CONFIG: rdata_next = {14'h0000, src_sel, 2'h0, dv.divisor};
         ADDR_STATE:  rdata_next = {24'h00_0000, fp_z_reg, fp_oe_n_reg,
                                    trig_b_oe_n_reg, trig_a_oe_n_reg,
                                    sel_clk_reg, dv.square, dv.half,
                                    dv.pulse};
         ADDR_BANKS:  rdata_next = {8'h00, front_panel_config_bank,
                                    trigger_enable_bank,
                                    divisor_high_and_select_bank,
                                    divisor_low_switch_bank};
         default:     rdata_next = RESET_RDATA;
      endcase
   end

   // capture read data in the setup cycle
   // RQ15 - read only access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= RESET_RDATA;
      end else if (setup_phase && !pwrite) begin
         prdata_reg <= rdata_next;
      end
   end

   assign prdata  = prdata_reg;
   assign pready  = 1'b1;                      // zero wait states
   assign pslverr = access_phase & (~addr_hit | pwrite);

endmodule

//--- hw/clkdiv_pkg.sv
// ======================================================================
// shared constants for the reference divider and output selector
package clkdiv_pkg;

   // ===================================================================
   // timing
   localparam int unsigned PCLK_PERIOD_NS = 25;   // 40 mhz bus clock
   localparam int unsigned REF_PERIOD_NS  = 100;  // 10 mhz reference
   // pclk cycles in one reference period (pulse width)
   localparam int unsigned PULSE_CYCLES   = REF_PERIOD_NS / PCLK_PERIOD_NS;

   // ===================================================================
   // divisor range
   localparam int unsigned DIV_W          = 14;
   localparam logic [13:0] DIV_MIN        = 14'h0003;
   localparam logic [13:0] DIV_MAX        = 14'h3fff;

   // ===================================================================
   // switch bank field positions (switch k sits at bit k-1)
   localparam int unsigned SEL_MSB_POS    = 0;   // high bank switch 1
   localparam int unsigned SEL_LSB_POS    = 1;   // high bank switch 2
   localparam int unsigned DIV_HI_LSB     = 2;   // high bank switches 3-8
   localparam int unsigned TRIG_A_EN_POS  = 0;   // trigger bank switch 1
   localparam int unsigned TRIG_B_EN_POS  = 1;   // trigger bank switch 2
   localparam int unsigned FP_Z_POS       = 0;   // panel bank switch 1
   localparam int unsigned FP_EN_POS      = 1;   // panel bank switch 2

   // ===================================================================
   // source select codes
   localparam logic [1:0] SEL_SQUARE      = 2'h0;  // square_wave_mode
   localparam logic [1:0] SEL_HALVE       = 2'h1;  // halve_mode
   localparam logic [1:0] SEL_DIRECT      = 2'h2;  // undivided reference
   localparam logic [1:0] SEL_PULSE       = 2'h3;  // pulse_divide_mode

   // switch level meaning: on reads 0, off reads 1
   localparam logic       SW_ON           = 1'b0;

   // ===================================================================
   // apb register map (byte addresses, read only)
   localparam logic [7:0]  ADDR_CONFIG    = 8'h00;
   localparam logic [7:0]  ADDR_STATE     = 8'h04;
   localparam logic [7:0]  ADDR_BANKS     = 8'h08;
   localparam logic [31:0] RESET_RDATA    = 32'h0000_0000;

endpackage

//--- hw/div_if.sv
`timescale 1ns/1ps
// ======================================================================
// carrier between the selector top and the divider core
interface div_if;
   import clkdiv_pkg::*;
   logic             ref_tick;   // one pclk at each reference rise
   logic [13:0]      divisor;    // effective divisor, already clamped
   logic             pulse;      // pulse_divide_mode pulse, one ref period
   logic             half;       // reference divided by two
   logic             square;     // square wave at ref/(2n)

   modport core (input ref_tick, input divisor,
                 output pulse, output half, output square);
   modport top  (output ref_tick, output divisor,
                 input pulse, input half, input square);
endinterface

//--- hw/div_core.sv
`timescale 1ns/1ps
// ======================================================================
// pulse_divide_mode counter, pulse former, halve and square stages
module div_core
   import clkdiv_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   div_if.core      dv
);

   logic [13:0] count_reg;
   logic [13:0] count_next;
   logic        pulse_reg;
   logic        half_reg;
   logic        square_reg;
   logic        wrap;

   // ===================================================================
   // counter wraps every n reference ticks
   // RQ2 - pulse_divide_mode
   assign wrap       = (count_reg >= dv.divisor - 14'h0001);
   assign count_next = wrap ? 14'h0000 : count_reg + 14'h0001;

   // counter and output stages advance on reference ticks only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_reg  <= 14'h0000;
         pulse_reg  <= 1'b0;
         half_reg   <= 1'b0;
         square_reg <= 1'b0;
      end else if (dv.ref_tick) begin
         count_reg  <= count_next;
         // RQ3 - one ref period pulse
         pulse_reg  <= wrap;
         // RQ4 - halve stage toggles
         half_reg   <= ~half_reg;
         // RQ16 - toggle per pulse
         if (wrap) begin
            square_reg <= ~square_reg;
         end
      end
   end

   assign dv.pulse  = pulse_reg;
   assign dv.half   = half_reg;
   assign dv.square = square_reg;

endmodule

//--- verification/clkdiv_checker.sv
`timescale 1ns/1ps
// ======================================================================
// port checks for the divider and output selector
module clkdiv_checker
   import clkdiv_pkg::*;
(
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       ref_clk,
   input wire logic [7:0] divisor_high_and_select_bank,
   input wire logic [3:0] trigger_enable_bank,
   input wire logic [3:0] front_panel_config_bank,
   input wire logic       trigger_out_first,
   input wire logic       trigger_out_first_oe_n,
   input wire logic       trigger_out_second,
   input wire logic       trigger_out_second_oe_n,
   input wire logic       front_panel_out,
   input wire logic       front_panel_oe_n,
   input wire logic       front_panel_z50
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // enables and impedance follow their switches one cycle late
   a_first_oe: assert property ($past(presetn) |->
      trigger_out_first_oe_n == $past(trigger_enable_bank[0]))
      else $error("first trigger enable wrong");
   a_second_oe: assert property ($past(presetn) |->
      trigger_out_second_oe_n == $past(trigger_enable_bank[1]))
      else $error("second trigger enable wrong");
   a_panel_oe: assert property ($past(presetn) |->
      front_panel_oe_n == $past(front_panel_config_bank[1]))
      else $error("panel enable wrong");
   a_imp_sel: assert property ($past(presetn) |->
      front_panel_z50 == $past(front_panel_config_bank[0]))
      else $error("impedance select wrong");
   // disabled outputs stay low, with all three enabled they carry one clock
   a_off_quiet: assert property (!((trigger_out_first_oe_n &&
      trigger_out_first) || (trigger_out_second_oe_n && trigger_out_second)
      || (front_panel_oe_n && front_panel_out)))
      else $error("disabled output active");
   a_same_clock: assert property (!trigger_out_first_oe_n &&
      !trigger_out_second_oe_n && !front_panel_oe_n |->
      trigger_out_first == trigger_out_second &&
      trigger_out_second == front_panel_out)
      else $error("enabled outputs differ");
   // pulse mode: one reference period wide
   a_pulse_width: assert property ($rose(trigger_out_first) &&
      (&divisor_high_and_select_bank[1:0]) |->
      trigger_out_first[*4] ##1 !trigger_out_first)
      else $error("pulse width wrong");
   // direct mode: reference two cycles late
   a_direct_path: assert property ($past(presetn, 2) &&
      divisor_high_and_select_bank[1:0] == 2'h1 && !trigger_out_first_oe_n
      |-> trigger_out_first == $past(ref_clk, 2))
      else $error("direct path wrong");
endmodule

bind clock_divider_output_select clkdiv_checker i_chk (.pclk, .presetn,
   .ref_clk, .divisor_high_and_select_bank, .trigger_enable_bank,
   .front_panel_config_bank, .trigger_out_first, .trigger_out_first_oe_n,
   .trigger_out_second, .trigger_out_second_oe_n, .front_panel_out,
   .front_panel_oe_n, .front_panel_z50);

//--- verification/clkdiv_partner.sv
`timescale 1ns/1ps
// ======================================================================
// reference oscillator and trigger line consumer
module clkdiv_partner (
   input  wire logic        pclk,
   output logic             ref_clk,
   input  wire logic        line_drv,
   input  wire logic        line_oe_n,
   input  wire logic        clr,
   output logic [15:0]      rises,
   output logic [15:0]      highs
);
   logic [1:0]  ph_reg = 2'h0;
   logic        prev_reg = 1'b1;
   logic        line;
   // released line rests at its pull-up level
   assign line = line_oe_n | line_drv;
   // free running reference, four pclk per period
   assign ref_clk = ph_reg[1];
   // edge and level counts on the line
   always @(posedge pclk) begin
      ph_reg <= ph_reg + 2'h1;
      prev_reg <= line;
      rises <= clr ? 16'h0000 : rises + 16'(line & ~prev_reg);
      highs <= clr ? 16'h0000 : highs + 16'(line);
   end
endmodule

//--- verification/clock_divider_output_select_tb_top.sv
`timescale 1ns/1ps
// ======================================================================
// self-checking bench for the divider and output selector
module clock_divider_output_select_tb_top;
   import clkdiv_pkg::*;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        ref_clk;
   logic [7:0]  divisor_low_switch_bank = 8'hff;
   logic [7:0]  divisor_high_and_select_bank = 8'hff;
   logic [3:0]  trigger_enable_bank = 4'hf;
   logic [3:0]  front_panel_config_bank = 4'hf;
   logic        trigger_out_first, trigger_out_first_oe_n;
   logic        trigger_out_second, trigger_out_second_oe_n;
   logic        front_panel_out, front_panel_oe_n, front_panel_z50;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready, pslverr;
   logic        clr = 1'b1;
   logic [15:0] rises, highs;
   int          n_fail = 0;
   int          checks_done = 0;

   // ===================================================================
   // design, far side and clock
   clock_divider_output_select i_dut (.pclk, .presetn, .ref_clk,
      .divisor_low_switch_bank, .divisor_high_and_select_bank,
      .trigger_enable_bank, .front_panel_config_bank,
      .trigger_out_first, .trigger_out_first_oe_n, .trigger_out_second,
      .trigger_out_second_oe_n, .front_panel_out, .front_panel_oe_n,
      .front_panel_z50, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr);
   clkdiv_partner i_far (.pclk, .ref_clk, .line_drv(trigger_out_first),
      .line_oe_n(trigger_out_first_oe_n), .clr, .rises, .highs);
   always #12.5 pclk = ~pclk;

   // ===================================================================
   // shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // switches move only while reset is held, spare ones stay off
   task automatic setup(input logic [13:0] n, input logic [1:0] s,
                        input logic [2:0] en, input logic z);
      presetn <= 1'b0;
      divisor_low_switch_bank <= n[7:0];
      divisor_high_and_select_bank <= {n[13:8], s[0], s[1]};
      trigger_enable_bank <= {2'b11, en[1:0]};
      front_panel_config_bank <= {2'b11, en[2], z};
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      repeat (100) @(posedge pclk);
   endtask
   // count rises and high cycles on the first trigger line
   task automatic window(input int w, input int er, input int eh);
      clr <= 1'b1;
      @(posedge pclk);
      clr <= 1'b0;
      repeat (w) @(posedge pclk);
      #1;
      chk(rises, er);
      chk(highs, eh);
      // hand back on an edge so the next stimulus starts there
      @(posedge pclk);
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [31:0] er,
                      input logic ee);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      if (!w) chk(prdata, er);
      chk(pslverr, ee);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // ===================================================================
   // scenarios
   task automatic t_modes();
      logic [1:0] s;
      int         p;
      for (int i = 0; i < 4; i++) begin
         s = 2'(i);
         p = (s == SEL_DIRECT) ? PULSE_CYCLES : (s == SEL_HALVE) ?
             2 * PULSE_CYCLES : (s == SEL_PULSE) ? 5 * PULSE_CYCLES :
             10 * PULSE_CYCLES;
         setup(14'h0005, s, 3'b110, 1'b0);
         window(400, 400 / p, (s == SEL_PULSE) ?
                400 / p * PULSE_CYCLES : 200);
      end
      $display("test modes done");
   endtask
   task automatic t_range();
      logic [13:0] nv [3] = '{14'h0003, 14'h0002, 14'h0103};
      int          ne;
      foreach (nv[i]) begin
         ne = (nv[i] < DIV_MIN) ? 3 : nv[i];
         setup(nv[i], SEL_PULSE, 3'b110, 1'b0);
         window(PULSE_CYCLES * ne * 3, 3, PULSE_CYCLES * 3);
      end
      $display("test range done");
   endtask
   task automatic t_enables();
      int         h [3];
      logic [3:0] v;
      for (int e = 0; e < 8; e++) begin
         setup(14'h0005, SEL_DIRECT, 3'(e), e[1]);
         h = '{0, 0, 0};
         repeat (16) begin
            @(posedge pclk);
            h[0] += trigger_out_first;
            h[1] += trigger_out_second;
            h[2] += front_panel_out;
         end
         v = {trigger_out_first_oe_n, trigger_out_second_oe_n,
              front_panel_oe_n, front_panel_z50};
         chk(v, {e[0], e[1], e[2], e[1]});
         for (int k = 0; k < 3; k++) chk(h[k], e[k] ? 0 : 8);
      end
      $display("test enables done");
   endtask
   task automatic t_apb();
      setup(14'h0103, SEL_HALVE, 3'b000, 1'b1);
      apb(1'b0, ADDR_CONFIG, 32'h0, 32'h0001_0103, 1'b0);
      apb(1'b0, ADDR_BANKS, 32'h0, 32'h00dc_0603, 1'b0);
      apb(1'b1, ADDR_CONFIG, 32'hffff_ffff, 32'h0, 1'b1);
      apb(1'b0, ADDR_CONFIG, 32'h0, 32'h0001_0103, 1'b0);
      apb(1'b0, 8'h0c, 32'h0, 32'h0000_0000, 1'b1);
      $display("test bus done");
   endtask

   // ===================================================================
   // verdict, main sequence and watchdog
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      t_modes();
      t_range();
      t_enables();
      t_apb();
      close_out();
   end
   initial begin
      repeat (20000) @(posedge pclk);
      n_fail++;
      close_out();
   end
endmodule
